// File: pac_ctrl_model.sv
// Controller model: select pin and analog monitors
`timescale 1ns/1ns
module pac_ctrl_model (
  // Clock
  input wire logic clk_in,
  // Pins to the sequencer
  output logic     rx_tx_select_out,
  output logic     pll_lock_out,
  output logic     supply_low_out
);
  initial begin
    rx_tx_select_out = 1'b1;
    pll_lock_out     = 1'b1;
    supply_low_out   = 1'b0;
  end
  // Select stays low for the whole slot
  task automatic slot(input bit open);
    @(posedge clk_in);
    rx_tx_select_out <= !open;
  endtask : slot
  task automatic fault(input bit lock, input int len);
    @(posedge clk_in);
    pll_lock_out   <= !lock;
    supply_low_out <= !lock;
    repeat (len) @(posedge clk_in);
    pll_lock_out   <= 1'b1;
    supply_low_out <= 1'b0;
  endtask : fault
endmodule : pac_ctrl_model

// File: pac_pkg.sv
// Package: register map, field positions and timing constants of the PA sequencer
package pac_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_MHZ        = 250;
  // Times in tenths of a microsecond
  localparam int unsigned T_PA_ON_TENTHS = 625;   // 62.5 us
  localparam int unsigned T_RECAL_TENTHS = 65;    // 6.5 us
  localparam int unsigned T_RX_TENTHS    = 700;   // 70 us
  localparam int unsigned T_PA_OFF_TENTHS = 1;    // 0.1 us, shortest
  localparam int unsigned PA_ON_CYC  = (T_PA_ON_TENTHS * CLK_MHZ + 9) / 10;
  localparam int unsigned RECAL_CYC  = (T_RECAL_TENTHS * CLK_MHZ + 9) / 10;
  localparam int unsigned RX_CYC     = (T_RX_TENTHS * CLK_MHZ + 9) / 10;
  localparam int unsigned PA_OFF_CYC = (T_PA_OFF_TENTHS * CLK_MHZ) / 10;
  localparam int unsigned CNT_W      = 16;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [3:0] OFS_CFG0   = 4'h0;
  localparam logic [3:0] OFS_TEST   = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_MASK   = 4'hc;

  // Configuration register 0 fields
  localparam int unsigned BIT_REF_DIV   = 1;
  localparam int unsigned BIT_TX_POWER  = 5;
  // Test register field
  localparam int unsigned TEST_LSB      = 0;
  localparam int unsigned TEST_W        = 3;
  // Status bits
  localparam int unsigned ST_LOCK_FAIL  = 0;
  localparam int unsigned ST_LOW_SUPPLY = 1;
  localparam int unsigned ST_SLOT_START = 2;
  localparam int unsigned ST_W          = 3;

  // Reset values
  localparam logic [5:0] CFG0_RST = 6'h00;
  localparam logic [2:0] TEST_RST = 3'h0;
  localparam logic [2:0] MASK_RST = 3'h0;

  // Reference divide ratios
  localparam logic [3:0] REF_DIV_LO = 4'h6;
  localparam logic [3:0] REF_DIV_HI = 4'hc;

  // ----------------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    PAC_RX      = 3'b000,
    PAC_TX_WAIT = 3'b001,
    PAC_TX_ON   = 3'b010,
    PAC_RX_WAIT = 3'b011
  } pac_state_t;

endpackage : pac_pkg

// File: pac_seq_assertions.sv
// Checker: timing and gating of the PA sequencer pins
`timescale 1ns/1ns
module pac_seq_assertions #(
  parameter int unsigned PA_ON_CYCLES = 20,
  parameter int unsigned RECAL_CYCLES = 5,
  parameter int unsigned RX_CYCLES    = 30
) (
  // Clock, reset and pins
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic rx_tx_select_in,
  input wire logic pll_lock_in,
  input wire logic supply_low_in,
  // Outputs watched
  input wire logic amp_enable_out,
  input wire logic recal_start_out,
  input wire logic rx_mode_out,
  input wire logic ref_tick_out
);
  logic [15:0] lo_q;
  logic [15:0] hi_q;
  logic        flt_q;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Cycles the select pin stood low or high; fault seen in slot
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      lo_q  <= 16'h0;
      hi_q  <= 16'h0;
      flt_q <= 1'b0;
    end else begin
      lo_q  <= rx_tx_select_in ? 16'h0 : lo_q + {15'h0, lo_q != 16'hffff};
      hi_q  <= !rx_tx_select_in ? 16'h0 : hi_q + {15'h0, hi_q != 16'hffff};
      flt_q <= !rx_tx_select_in && (flt_q || supply_low_in || !pll_lock_in);
    end
  end
  chk_amp_rise_time: assert property (
    $rose(amp_enable_out) |-> lo_q >= PA_ON_CYCLES && lo_q <= PA_ON_CYCLES + 6)
    else $error("amp enable rose off time");
  chk_amp_drop_time: assert property (
    $rose(rx_tx_select_in) |-> ##[1:24] !amp_enable_out) else $error("amp enable late off");
  chk_recal_time: assert property (
    recal_start_out |-> hi_q >= RECAL_CYCLES && hi_q <= RECAL_CYCLES + 6)
    else $error("recalibration off time");
  chk_rx_mode_time: assert property (
    $rose(rx_mode_out) |-> hi_q >= RX_CYCLES && hi_q <= RX_CYCLES + 6)
    else $error("receive mode off time");
  chk_tick_spacing: assert property (
    ref_tick_out |=> !ref_tick_out [*5]) else $error("ticks too close");
  chk_fault_gate: assert property (
    (supply_low_in || !pll_lock_in) [*6] |-> !amp_enable_out) else $error("fault not gating");
  chk_fault_hold: assert property (
    flt_q && $past(flt_q, 6) |-> !amp_enable_out) else $error("fault latch lost");
  chk_amp_tx_only: assert property (
    amp_enable_out |-> !rx_mode_out) else $error("amp on in receive");
  cover property ($rose(amp_enable_out));
  cover property (recal_start_out);
  cover property (flt_q && $past(flt_q, 6));
endmodule : pac_seq_assertions

// File: pac_sequencer.sv
// PA enable and power-control sequencer with Avalon-MM register slave
//
// Operation
// RL1: Amp enable high only while the amplifier should run, low otherwise.
// RL2: Lock failure or low supply suppresses the amp enable.
// RL3: Faults latch and keep amp enable off for the rest of the slot.
// RL4: Fault latches clear when the transmit slot ends.
// RL5: Open-drain power-control pin follows the transmit power level bit.
// RL6: Power bit writable anytime; pin updates only at slot start.
// RL7: Amp enable rises 62.5 us after rx_tx_select falls.
// RL8: Amp enable drops within 0.1 us after rx_tx_select rises.
// RL9: Recalibration starts 6.5 us after rx_tx_select rises.
// RL10: Receive mode reached 70 us after rx_tx_select rises.
// RL11: Comparison tick is reference divided by 6 or 12 per select bit.
// RL12: Analog test mode hands both test pins to observation ports.
// RL13: Power bit at position 5; one pulls pin low, zero floats it.
// RL14: Divide select at position 1; zero divides by 6, one by 12.
// RL15: Controller holds select low through each slot, high in receive.
// RL16: Delays are counters on the timing clock with derived terminal counts.
`timescale 1ns/1ns
module pac_sequencer
  import pac_pkg::*;
#(
  parameter int unsigned PA_ON_CYCLES = PA_ON_CYC,
  parameter int unsigned RECAL_CYCLES = RECAL_CYC,
  parameter int unsigned RX_CYCLES    = RX_CYC
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // Pins from the controller and analog monitors
  input  wire logic        rx_tx_select_in,
  input  wire logic        pll_lock_in,
  input  wire logic        supply_low_in,
  // Pins to the amplifier and test access
  output logic             amp_enable_out,
  output logic             power_ctrl_test_pin_out,
  output logic             power_ctrl_test_pin_oe_out,
  output logic             signal_strength_test_pin_out,
  output logic             recal_start_out,
  output logic             rx_mode_out,
  output logic             ref_tick_out,
  output logic             irq_out
);
  import pac_pkg::*;

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  // Counters are CNT_W wide and the receive wait must outlast recalibration
  if (PA_ON_CYCLES < 2 || RECAL_CYCLES < 1 || RX_CYCLES <= RECAL_CYCLES ||
      PA_ON_CYCLES >= (1 << CNT_W) || RX_CYCLES >= (1 << CNT_W)) begin : g_bad_timing
    $error("pac_sequencer: timing counts out of range");
  end

  // ----------------------------------------------------------------------
  // Terminal counts
  // ----------------------------------------------------------------------
  localparam logic [CNT_W-1:0] PA_ON_T = CNT_W'(PA_ON_CYCLES - 1);
  localparam logic [CNT_W-1:0] RECAL_T = CNT_W'(RECAL_CYCLES - 1);
  localparam logic [CNT_W-1:0] RX_T    = CNT_W'(RX_CYCLES - 1);

  // ----------------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [1:0]       sync_sel;
    logic [1:0]       sync_lock;
    logic [1:0]       sync_low;
    logic             sel_prev;
    pac_state_t       state;
    logic [CNT_W-1:0] cnt;
    logic             fault;
    logic             tx_power_level_bit;
    logic             ref_divide_bit;
    logic [TEST_W-1:0] analog_test_field;
    logic             pin_power;
    logic [ST_W-1:0]  status;
    logic [ST_W-1:0]  mask;
    logic [3:0]       div_cnt;
    logic             ref_tick;
    logic             amp_en;
    logic             recal;
    logic             rx_mode;
    logic             wait_n;
    logic             wait_req;
    logic [31:0]      rdata;
    logic             pin_out;
    logic             pin_oe;
    logic             ssi_out;
    logic             irq;
  } pac_regs_t;

  pac_regs_t r_q;
  pac_regs_t r_d;

  logic sel_s;
  logic fall_edge;
  logic rise_edge;
  logic fault_now;
  logic acc;
  logic [3:0] div_end;
  logic [31:0] rd_val;
  logic [ST_W-1:0] ev;

  always_comb begin
    r_d       = r_q;
    sel_s     = r_q.sync_sel[1];
    fall_edge = r_q.sel_prev & ~sel_s;
    rise_edge = ~r_q.sel_prev & sel_s;
    fault_now = ~r_q.sync_lock[1] | r_q.sync_low[1];
    acc       = (avs_read_in | avs_write_in) & r_q.wait_n;
    ev        = '0;
    rd_val    = 32'h0000_0000;

    // --------------------------------------------------------------------
    // Input synchronisers
    // --------------------------------------------------------------------
    r_d.sync_sel  = {r_q.sync_sel[0], rx_tx_select_in};
    r_d.sync_lock = {r_q.sync_lock[0], pll_lock_in};
    r_d.sync_low  = {r_q.sync_low[0], supply_low_in};
    r_d.sel_prev  = sel_s;

    // --------------------------------------------------------------------
    // Reference divider
    // --------------------------------------------------------------------
    div_end = r_q.ref_divide_bit ? REF_DIV_HI : REF_DIV_LO; // RL11 RL14
    r_d.ref_tick = 1'b0;
    if (r_q.div_cnt >= div_end - 4'h1) begin
      r_d.div_cnt  = 4'h0;
      r_d.ref_tick = 1'b1;                                    // RL11
    end else begin
      r_d.div_cnt = r_q.div_cnt + 4'h1;
    end

    // --------------------------------------------------------------------
    // Slot sequencer
    // --------------------------------------------------------------------
    r_d.recal = 1'b0;
    if (r_q.state != PAC_RX) begin
      r_d.cnt = r_q.cnt + 1'b1;                               // RL16
    end
    if (fall_edge) begin                                      // RL15
      r_d.state     = PAC_TX_WAIT;
      r_d.cnt       = '0;
      r_d.rx_mode   = 1'b0;
      r_d.pin_power = r_q.tx_power_level_bit;                 // RL6
      ev[ST_SLOT_START] = 1'b1;
    end else if (rise_edge) begin
      r_d.state  = PAC_RX_WAIT;
      r_d.cnt    = '0;
      r_d.amp_en = 1'b0;                                      // RL8
      r_d.fault  = 1'b0;                                      // RL4
    end else begin
      case (r_q.state)
        PAC_TX_WAIT: begin
          if (r_q.cnt == PA_ON_T) begin                       // RL7
            r_d.state = PAC_TX_ON;
          end
        end
        PAC_TX_ON: begin
        end
        PAC_RX_WAIT: begin
          if (r_q.cnt == RECAL_T) begin
            r_d.recal = 1'b1;                                 // RL9
          end
          if (r_q.cnt == RX_T) begin
            r_d.state   = PAC_RX;                             // RL10
            r_d.rx_mode = 1'b1;
          end
        end
        default: begin
          r_d.state = PAC_RX;
        end
      endcase
    end

    // --------------------------------------------------------------------
    // Fault latch: holds for the rest of the transmit slot
    // --------------------------------------------------------------------
    if (r_d.state == PAC_TX_WAIT || r_d.state == PAC_TX_ON) begin
      if (fault_now) begin
        r_d.fault = 1'b1;                                     // RL3
      end
    end
    if (fault_now && !sel_s) begin
      ev[ST_LOCK_FAIL]  = ~r_q.sync_lock[1];
      ev[ST_LOW_SUPPLY] = r_q.sync_low[1];
    end
    r_d.amp_en = (r_d.state == PAC_TX_ON) & ~r_d.fault & ~fault_now; // RL1 RL2 RL8

    // --------------------------------------------------------------------
    // Pins
    // --------------------------------------------------------------------
    if (r_q.analog_test_field != TEST_RST) begin              // RL12
      r_d.pin_out = r_q.analog_test_field[0];
      r_d.pin_oe  = r_q.analog_test_field[1];
      r_d.ssi_out = r_q.analog_test_field[2];
    end else begin
      r_d.pin_out = 1'b0;
      r_d.pin_oe  = r_q.pin_power;                            // RL5 RL13
      r_d.ssi_out = 1'b0;
    end

    // --------------------------------------------------------------------
    // Register slave: one wait cycle per access
    // --------------------------------------------------------------------
    r_d.wait_n = 1'b0;
    if ((avs_read_in | avs_write_in) && !r_q.wait_n) begin
      r_d.wait_n = 1'b1;
    end
    // Registered so that the pin comes straight from a flop
    r_d.wait_req = ~r_d.wait_n;

    // --------------------------------------------------------------------
    // Register read: data stand from the same edge at which waitrequest drops
    // --------------------------------------------------------------------
    case (avs_address_in)
      OFS_CFG0: begin
        rd_val[BIT_REF_DIV]  = r_q.ref_divide_bit;
        rd_val[BIT_TX_POWER] = r_q.tx_power_level_bit;
      end
      OFS_TEST:   rd_val[TEST_LSB +: TEST_W] = r_q.analog_test_field;
      OFS_STATUS: rd_val[ST_W-1:0] = r_q.status;
      OFS_MASK:   rd_val[ST_W-1:0] = r_q.mask;
      default:    rd_val = 32'h0000_0000;
    endcase
    // Captured with the ack flop, so the data stand at the edge that samples it
    if (avs_read_in && !r_q.wait_n) begin
      r_d.rdata = rd_val;
    end

    // --------------------------------------------------------------------
    // Register write: takes effect at the edge that sees waitrequest low
    // --------------------------------------------------------------------
    r_d.status = r_q.status;
    if (acc && avs_write_in && avs_byteenable_in[0]) begin
      case (avs_address_in)
        OFS_CFG0: begin
          r_d.ref_divide_bit     = avs_writedata_in[BIT_REF_DIV];
          r_d.tx_power_level_bit = avs_writedata_in[BIT_TX_POWER]; // RL6
        end
        OFS_TEST:   r_d.analog_test_field = avs_writedata_in[TEST_LSB +: TEST_W];
        OFS_STATUS: r_d.status = r_q.status & ~avs_writedata_in[ST_W-1:0];
        OFS_MASK:   r_d.mask = avs_writedata_in[ST_W-1:0];
        default: begin
        end
      endcase
    end

    // --------------------------------------------------------------------
    // Status and interrupt: a new event wins over a clear in the same cycle
    // --------------------------------------------------------------------
    r_d.status = r_d.status | ev;
    r_d.irq    = |(r_d.status & r_d.mask);
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      // Synchronisers reset to the idle pin levels, so no false edge follows
      r_q                    <= '0;
      r_q.sync_sel           <= 2'b11;
      r_q.sel_prev           <= 1'b1;
      r_q.sync_lock          <= 2'b11;
      r_q.state              <= PAC_RX;
      r_q.rx_mode            <= 1'b1;
      r_q.ref_divide_bit     <= CFG0_RST[BIT_REF_DIV];
      r_q.tx_power_level_bit <= CFG0_RST[BIT_TX_POWER];
      r_q.analog_test_field  <= TEST_RST;
      r_q.mask               <= MASK_RST;
      r_q.wait_req           <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  // ----------------------------------------------------------------------
  // Output ports
  // ----------------------------------------------------------------------
  assign avs_readdata_out             = r_q.rdata;
  assign avs_waitrequest_out          = r_q.wait_req;
  assign amp_enable_out               = r_q.amp_en;
  assign power_ctrl_test_pin_out      = r_q.pin_out;
  assign power_ctrl_test_pin_oe_out   = r_q.pin_oe;
  assign signal_strength_test_pin_out = r_q.ssi_out;
  assign recal_start_out              = r_q.recal;
  assign rx_mode_out                  = r_q.rx_mode;
  assign ref_tick_out                 = r_q.ref_tick;
  assign irq_out                      = r_q.irq;

endmodule : pac_sequencer

// File: testbench.sv
// Testbench: registers, slot sequencing and faults of the PA sequencer
`timescale 1ns/1ns
module testbench;
  import pac_pkg::*;
  localparam int unsigned PA_ON = 20;
  localparam int unsigned RX_T  = 30;
  logic        clk_in, rst_in, rd, wr, wait_r, amp, oe, pin, ssi, irq, tick, sel, lock, low;
  logic        rxm;
  logic [3:0]  adr;
  logic [31:0] wdat, rdat, rd_data;
  int          mismatches, samples_checked, g;
  pac_sequencer #(.PA_ON_CYCLES(PA_ON), .RECAL_CYCLES(5), .RX_CYCLES(RX_T)) i_dut (
    .clk_in(clk_in), .rst_in(rst_in), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(4'hf),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wait_r), .rx_tx_select_in(sel),
    .pll_lock_in(lock), .supply_low_in(low), .amp_enable_out(amp),
    .power_ctrl_test_pin_out(pin), .power_ctrl_test_pin_oe_out(oe),
    .signal_strength_test_pin_out(ssi), .recal_start_out(), .rx_mode_out(rxm),
    .ref_tick_out(tick), .irq_out(irq));
  pac_ctrl_model i_ctrl (.clk_in(clk_in), .rx_tx_select_out(sel), .pll_lock_out(lock),
    .supply_low_out(low));
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
      mismatches++;
    end
  endtask : check
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    adr  <= a;
    wdat <= d;
    wr   <= w;
    rd   <= !w;
    do @(posedge clk_in); while (wait_r !== 1'b0);
    rd_data = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic rd_chk(input string nm, input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(nm, e, rd_data);
  endtask : rd_chk
  task automatic tick_gap();
    g = 0;
    while (tick !== 1'b1 && g < 40) begin
      @(posedge clk_in);
      g++;
    end
    g = 0;
    do begin
      @(posedge clk_in);
      g++;
    end while (tick !== 1'b1 && g < 40);
  endtask : tick_gap
  task automatic complete_run();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  task automatic slot_wait(input bit open, input int n);
    i_ctrl.slot(open);
    repeat (n) @(posedge clk_in);
  endtask : slot_wait
  initial begin
    #40000;
    mismatches++;
    complete_run();
  end
  initial begin
    {rst_in, rd, wr, adr, wdat} = {1'b1, 38'h0};
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    rd_chk("cfg0", OFS_CFG0, 32'h0);
    rd_chk("test", OFS_TEST, 32'h0);
    rd_chk("unmapped", 4'h2, 32'h0);
    tick_gap();
    check("tick6", 6, g);
    bus(1'b1, OFS_CFG0, 32'h22);
    tick_gap();
    tick_gap();
    check("tick12", 12, g);
    check("oe_hold", 0, oe);
    bus(1'b1, OFS_MASK, 32'h7);
    slot_wait(1'b1, PA_ON - 2);
    check("amp_early", 0, amp);
    repeat (10) @(posedge clk_in);
    check("amp_on", 1, amp);
    check("rx_mode_off", 0, rxm);
    check("pin_low", 32'h1, {pin, oe});
    check("irq_on", 1, irq);
    bus(1'b1, OFS_CFG0, 32'h02);
    check("oe_keep", 1, oe);
    slot_wait(1'b0, RX_T + 10);
    check("amp_off", 0, amp);
    check("rx_mode_on", 1, rxm);
    rd_chk("status", OFS_STATUS, 32'h4);
    bus(1'b1, OFS_STATUS, 32'h7);
    rd_chk("status_clr", OFS_STATUS, 32'h0);
    check("irq_off", 0, irq);
    slot_wait(1'b1, PA_ON + 8);
    check("oe_new", 0, oe);
    i_ctrl.fault(1'b0, 8);
    repeat (PA_ON + 8) @(posedge clk_in);
    check("amp_held", 0, amp);
    rd_chk("status_low", OFS_STATUS, 32'h6);
    slot_wait(1'b0, RX_T + 10);
    slot_wait(1'b1, 8);
    i_ctrl.fault(1'b1, 8);
    repeat (PA_ON + 8) @(posedge clk_in);
    check("amp_lock", 0, amp);
    slot_wait(1'b0, RX_T + 10);
    slot_wait(1'b1, PA_ON + 10);
    check("amp_again", 1, amp);
    slot_wait(1'b0, RX_T + 10);
    bus(1'b1, OFS_TEST, 32'h7);
    repeat (3) @(posedge clk_in);
    check("test_pins", 32'h7, {ssi, oe, pin});
    complete_run();
  end
endmodule : testbench
bind pac_sequencer pac_seq_assertions #(.PA_ON_CYCLES(PA_ON_CYCLES),
  .RECAL_CYCLES(RECAL_CYCLES), .RX_CYCLES(RX_CYCLES)) i_chk (.clk_in(clk_in),
  .rst_in(rst_in), .rx_tx_select_in(rx_tx_select_in), .pll_lock_in(pll_lock_in),
  .supply_low_in(supply_low_in), .amp_enable_out(amp_enable_out),
  .recal_start_out(recal_start_out), .rx_mode_out(rx_mode_out), .ref_tick_out(ref_tick_out));
